// ===== rtl/tmr16_pkg.sv
// Purpose: Shared constants for the 16-bit interval/PWM/capture timer
// Assumes: 8-bit register port, one clock domain at 250 MHz
// Notes: Offsets, fields, reset values and encodings live here only
package tmr16_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] TMR16_ADDR_CTRL = 4'h0;
  localparam logic [3:0] TMR16_ADDR_REF_LO = 4'h1;
  localparam logic [3:0] TMR16_ADDR_REF_HI = 4'h2;
  localparam logic [3:0] TMR16_ADDR_CNT_LO = 4'h3;
  localparam logic [3:0] TMR16_ADDR_CNT_HI = 4'h4;
  localparam logic [3:0] TMR16_ADDR_PEND = 4'h5;
  localparam logic [3:0] TMR16_ADDR_PCFG = 4'h6;
  localparam logic [3:0] TMR16_ADDR_STAT = 4'h7;
  localparam logic [3:0] TMR16_ADDR_MASK = 4'h8;
  // Control register fields
  localparam int TMR16_CTRL_SEL_HI = 7;
  localparam int TMR16_CTRL_SEL_LO = 5;
  localparam int TMR16_CTRL_MODE_HI = 4;
  localparam int TMR16_CTRL_MODE_LO = 4;
  localparam int TMR16_CTRL_CLR = 3;
  localparam int TMR16_CTRL_EDGE = 2;
  localparam int TMR16_CTRL_MIE = 1;
  localparam int TMR16_CTRL_OIE = 0;
  localparam logic [7:0] TMR16_CTRL_RESET = 8'h00;
  // Clock select codes
  localparam logic [2:0] TMR16_SEL_D1024 = 3'h0;
  localparam logic [2:0] TMR16_SEL_D256 = 3'h1;
  localparam logic [2:0] TMR16_SEL_D64 = 3'h2;
  localparam logic [2:0] TMR16_SEL_D8 = 3'h3;
  localparam logic [2:0] TMR16_SEL_D1 = 3'h4;
  localparam logic [2:0] TMR16_SEL_EXT_RISE = 3'h5;
  localparam logic [2:0] TMR16_SEL_EXT_FALL = 3'h6;
  localparam logic [2:0] TMR16_SEL_STOP = 3'h7;
  // Pending bit positions and capture source code
  localparam int TMR16_PND_OVF = 2;
  localparam int TMR16_PND_MC = 3;
  localparam logic [1:0] TMR16_CAPSRC_PIN = 2'h0;
  // Interrupt status bits
  localparam int TMR16_ST_OVF = 0;
  localparam int TMR16_ST_MC = 1;
  localparam int TMR16_PRESC_W = 10;
  localparam logic [15:0] TMR16_CNT_MAX = 16'hFFFF;
  typedef enum logic [1:0] {
    TMR16_MODE_INTERVAL,
    TMR16_MODE_CAPTURE,
    TMR16_MODE_PWM
  } tmr16_mode_e;
endpackage

// ===== rtl/tmr16_tick_if.sv
// Purpose: Carries the counting tick from the clock selector to the core
// Assumes: Single clock domain
// Notes: One-cycle pulse per active timer clock edge
`timescale 1ns/1ns
interface tmr16_tick_if;
  logic tick;
  logic [2:0] sel;
  modport src (input sel, output tick);
  modport dst (output sel, input tick);
endinterface

// ===== rtl/tmr16_clk_sel.sv
// Purpose: Prescaler and timer clock selection
// Assumes: External count clock synchronous to clk_in
// Notes: Emits one tick per selected divided or external edge
`timescale 1ns/1ns
module tmr16_clk_sel
  import tmr16_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // External count clock
  input wire logic ext_clk_in,
  // Tick towards the core
  tmr16_tick_if.src tk
);
  logic [TMR16_PRESC_W-1:0] presc;
  logic [TMR16_PRESC_W-1:0] next_presc;
  logic ext_prev;
  logic next_tick;
  logic ext_rise;
  logic ext_fall;
  logic tick_r;

  ///////////////////////////////////////////////////////////////////////
  // Divider taps: a tick when the low bits roll over to zero
  assign next_presc = presc + 1'b1;
  assign ext_rise = ext_clk_in & ~ext_prev;
  assign ext_fall = ~ext_clk_in & ext_prev;
  always_comb begin
    case (tk.sel)
      TMR16_SEL_D1024: next_tick = (presc == '1);
      TMR16_SEL_D256: next_tick = (presc[7:0] == 8'hFF);
      TMR16_SEL_D64: next_tick = (presc[5:0] == 6'h3F);
      TMR16_SEL_D8: next_tick = (presc[2:0] == 3'h7);
      TMR16_SEL_D1: next_tick = 1'b1;
      TMR16_SEL_EXT_RISE: next_tick = ext_rise;
      TMR16_SEL_EXT_FALL: next_tick = ext_fall;
      default: next_tick = 1'b0; // Stopped
    endcase
  end
  assign tk.tick = tick_r;

  // Free-running prescaler; tick registered for clean timing
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      presc <= '0;
      ext_prev <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      presc <= next_presc;
      ext_prev <= ext_clk_in;
      tick_r <= next_tick;
    end
  end
endmodule

// ===== rtl/tmr16_top.sv
// Purpose: 16-bit timer with interval, PWM and capture modes
// Assumes: Pins synchronous to clk_in; 8-bit register port
// Notes: Reference register doubles as capture register
// What this block does
// - Two interrupt requests: overflow and match/capture, distinct.
// - Overflow pending clears on service ack or software zero write.
// - Interval mode: match raises request, clears counter, counting goes on.
// - Interval mode: toggle output inverts on every match.
// - PWM mode: match leaves counter alone; it wraps FFFF to 0000.
// - PWM output low while reference <= counter, else high.
// - PWM period is 65536 timer clocks.
// - Capture mode: input edge copies counter into data register.
// - Capture edge selectable rising or falling.
// - Capture source field value 00 selects the capture pin.
// - Capture mode: overflow request on every counter overflow.
// - Capture mode: match/capture request on every capture load.
// - Timer clock: sysclk/1024,/256,/64,/8,/1 or external pin.
// - Writing one to control bit 3 clears counter; control resets 00.
// - Select bits 7..5 at 111 stop the counter.
`timescale 1ns/1ns
module tmr16_top
  import tmr16_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Register port
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Interrupt service acknowledges
  input wire logic ovf_ack_in,
  // Pins
  input wire logic external_count_clock_in,
  input wire logic capture_input_pin_in,
  output logic pulse_output_pin_out,
  output logic toggle_output_pin_out,
  // Interrupt outputs
  output logic overflow_irq_out,
  output logic match_capture_irq_out,
  output logic irq_out
);
  logic [7:0] timer_control_reg;
  logic [15:0] ref_data;
  logic [15:0] cnt;
  logic [1:0] pend;
  logic [1:0] port_pin_config_high;
  logic [1:0] stat;
  logic [1:0] mask;
  logic cap_prev;
  logic toggle_q;
  logic pwm_q;
  logic [7:0] next_rdata;
  logic [15:0] next_cnt;
  tmr16_mode_e mode;
  logic pcap_en;
  logic pcap_cfg;
  logic cap_rise_sel;
  logic clr_wr;
  logic tick;
  logic match;
  logic wrap;
  logic ovf_evt;
  logic match_evt;
  logic cap_edge;
  logic cap_evt;
  logic mc_evt;
  logic wr_ctrl;
  logic wr_pend;
  logic rd_stat;
  tmr16_tick_if tk ();

  ///////////////////////////////////////////////////////////////////////
  // Clock selection
  tmr16_clk_sel u_clk_sel (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .ext_clk_in(external_count_clock_in),
    .tk(tk)
  );
  assign tk.sel = timer_control_reg[TMR16_CTRL_SEL_HI:TMR16_CTRL_SEL_LO];
  assign tick = tk.tick;

  ///////////////////////////////////////////////////////////////////////
  // Mode decode; bit 4 picks PWM, else capture when the capture enable (port config bit 2) is set
  assign mode = timer_control_reg[TMR16_CTRL_MODE_HI] ? TMR16_MODE_PWM :
                (pcap_en ? TMR16_MODE_CAPTURE : TMR16_MODE_INTERVAL);

  // Capture enable lives in config bit 2 of the port config register
  assign pcap_en = pcap_cfg;
  assign cap_rise_sel = timer_control_reg[TMR16_CTRL_EDGE];

  ///////////////////////////////////////////////////////////////////////
  // Counter events
  assign wr_ctrl = wr_in && (addr_in == TMR16_ADDR_CTRL);
  assign wr_pend = wr_in && (addr_in == TMR16_ADDR_PEND);
  assign rd_stat = rd_in && (addr_in == TMR16_ADDR_STAT);
  assign clr_wr = wr_ctrl && wdata_in[TMR16_CTRL_CLR];
  assign match = tick && (cnt == ref_data) &&
                 (mode == TMR16_MODE_INTERVAL);
  assign match_evt = match;
  assign wrap = tick && (cnt == TMR16_CNT_MAX) && !match;
  assign ovf_evt = wrap;
  assign cap_edge = cap_rise_sel ? (capture_input_pin_in & ~cap_prev) :
                    (~capture_input_pin_in & cap_prev);
  assign cap_evt = cap_edge && (mode == TMR16_MODE_CAPTURE) &&
                   (port_pin_config_high == TMR16_CAPSRC_PIN);
  assign mc_evt = match_evt || cap_evt;

  // Next counter: clear on write or interval match, else +1 per tick
  always_comb begin
    if (clr_wr || match) begin
      next_cnt = '0;
    end else if (tick) begin
      next_cnt = cnt + 16'h0001; // wraps naturally
    end else begin
      next_cnt = cnt;
    end
  end

  // Counter, control and configuration registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cnt <= '0;
      timer_control_reg <= TMR16_CTRL_RESET;
      ref_data <= '0;
      port_pin_config_high <= TMR16_CAPSRC_PIN;
      pcap_cfg <= 1'b0;
      mask <= '0;
    end else begin
      cnt <= next_cnt;
      if (wr_ctrl) begin
        timer_control_reg <= wdata_in & 8'hF7; // Clear bit self-clears
      end
      if (cap_evt) begin
        ref_data <= cnt;
      end else if (wr_in && addr_in == TMR16_ADDR_REF_LO) begin
        ref_data[7:0] <= wdata_in;
      end else if (wr_in && addr_in == TMR16_ADDR_REF_HI) begin
        ref_data[15:8] <= wdata_in;
      end
      if (wr_in && addr_in == TMR16_ADDR_PCFG) begin
        port_pin_config_high <= wdata_in[1:0];
        pcap_cfg <= wdata_in[2];
      end
      if (wr_in && addr_in == TMR16_ADDR_MASK) begin
        mask <= wdata_in[1:0];
      end
    end
  end

  ///////////////////////////////////////////////////////////////////////
  // Pending flags; a set in the same cycle beats any clear
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pend <= '0;
    end else begin
      if (ovf_evt) begin
        pend[0] <= 1'b1;
      end else if (ovf_ack_in ||
                   (wr_pend && !wdata_in[TMR16_PND_OVF])) begin
        pend[0] <= 1'b0;
      end
      if (mc_evt) begin
        pend[1] <= 1'b1;
      end else if (wr_pend && !wdata_in[TMR16_PND_MC]) begin
        pend[1] <= 1'b0; // software only
      end
    end
  end

  // Sticky status cleared by reading it; events win over the read
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      stat <= '0;
    end else begin
      stat[TMR16_ST_OVF] <= ovf_evt | (stat[TMR16_ST_OVF] & ~rd_stat);
      stat[TMR16_ST_MC] <= mc_evt | (stat[TMR16_ST_MC] & ~rd_stat);
    end
  end

  // Two separate requests, gated by their enables
  assign overflow_irq_out = pend[0] & timer_control_reg[TMR16_CTRL_OIE];
  assign match_capture_irq_out = pend[1] &
                                 timer_control_reg[TMR16_CTRL_MIE];
  assign irq_out = |(stat & mask);

  ///////////////////////////////////////////////////////////////////////
  // Pin outputs from flip-flops
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cap_prev <= 1'b0;
      toggle_q <= 1'b0;
      pwm_q <= 1'b0;
    end else begin
      cap_prev <= capture_input_pin_in;
      if (match_evt) begin
        toggle_q <= ~toggle_q;
      end
      pwm_q <= (mode == TMR16_MODE_PWM) && (ref_data > next_cnt);
    end
  end
  assign pulse_output_pin_out = pwm_q;
  assign toggle_output_pin_out = toggle_q;

  ///////////////////////////////////////////////////////////////////////
  // Read mux; unmapped reads return zero
  always_comb begin
    case (addr_in)
      TMR16_ADDR_CTRL: next_rdata = timer_control_reg;
      TMR16_ADDR_REF_LO: next_rdata = ref_data[7:0];
      TMR16_ADDR_REF_HI: next_rdata = ref_data[15:8];
      TMR16_ADDR_CNT_LO: next_rdata = cnt[7:0];
      TMR16_ADDR_CNT_HI: next_rdata = cnt[15:8];
      TMR16_ADDR_PEND: next_rdata = {4'h0, pend, 2'h0};
      TMR16_ADDR_PCFG: next_rdata = {5'h00, pcap_cfg,
                                     port_pin_config_high};
      TMR16_ADDR_STAT: next_rdata = {6'h00, stat};
      TMR16_ADDR_MASK: next_rdata = {6'h00, mask};
      default: next_rdata = 8'h00;
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= rd_in ? next_rdata : 8'h00;
    end
  end

  ///////////////////////////////////////////////////////////////////////
  // Checks
  a_match_clears: assert property (@(posedge clk_in) disable iff (reset_in)
    match |=> cnt == 16'h0000) else $error("match did not clear");
  a_toggle_flip: assert property (@(posedge clk_in) disable iff (reset_in)
    match |=> toggle_q != $past(toggle_q)) else $error("no toggle");
  a_pwm_wraps: assert property (@(posedge clk_in) disable iff (reset_in)
    (mode == TMR16_MODE_PWM && tick && cnt == TMR16_CNT_MAX && !clr_wr)
    |=> cnt == 16'h0000) else $error("pwm wrap wrong");
  a_pwm_level: assert property (@(posedge clk_in) disable iff (reset_in)
    (mode == TMR16_MODE_PWM) && $stable(mode) |=>
    pwm_q == (ref_data > cnt) || $past(cap_evt))
    else $error("pwm level wrong");
  a_capture_load: assert property (@(posedge clk_in) disable iff (reset_in)
    cap_evt |=> ref_data == $past(cnt) && pend[1])
    else $error("capture load lost");
  a_ovf_pend: assert property (@(posedge clk_in) disable iff (reset_in)
    ovf_evt |=> pend[0]) else $error("overflow not pended");
  a_mc_sticky: assert property (@(posedge clk_in) disable iff (reset_in)
    pend[1] && !(wr_pend && !wdata_in[TMR16_PND_MC]) |=> pend[1])
    else $error("mc pending lost");
  a_stop_holds: assert property (@(posedge clk_in) disable iff (reset_in)
    (tk.sel == TMR16_SEL_STOP) && $past(tk.sel == TMR16_SEL_STOP) &&
    !clr_wr |=> $stable(cnt)) else $error("stopped counter moved");
  a_clear_write: assert property (@(posedge clk_in) disable iff (reset_in)
    clr_wr |=> cnt == 16'h0000) else $error("clear ignored");
  c_match: cover property (@(posedge clk_in) match);
  c_capture: cover property (@(posedge clk_in) cap_evt);
  c_wrap: cover property (@(posedge clk_in) wrap);
endmodule

// ===== bench/tmr16_pin_model.sv
// Purpose: Far-side pin model: external count clock and capture source
// Assumes: Pins are sampled on clk_in rising edges
// Notes: Lines stand still between bursts; outputs are only a load
`timescale 1ns/1ns
module tmr16_pin_model (
  // Clock
  input wire logic clk_in,
  // Pins towards the timer
  output logic ext_clk_out,
  output logic cap_pin_out,
  // Pins from the timer
  input wire logic pulse_in,
  input wire logic toggle_in
);
  // Load side: count toggle flips and pulse rises seen at the pins
  int toggles = 0;
  int pulse_rises = 0;
  logic tog_prev = 1'b0;
  logic pulse_prev = 1'b0;
  always @(posedge clk_in) begin
    tog_prev <= toggle_in;
    pulse_prev <= pulse_in;
    if (toggle_in !== tog_prev) toggles <= toggles + 1;
    if (pulse_in === 1'b1 && pulse_prev === 1'b0)
      pulse_rises <= pulse_rises + 1;
  end
  // Quiet levels until a burst is asked for
  initial begin
    ext_clk_out = 1'b0;
    cap_pin_out = 1'b0;
  end
  // Slow clock, 5 system cycles per period, so the sync never misses one
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge clk_in);
      ext_clk_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      ext_clk_out <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
  endtask
  // One capture edge, then time for the load to settle
  task automatic cap_to(input logic v);
    @(posedge clk_in);
    cap_pin_out <= v;
    repeat (4) @(posedge clk_in);
  endtask
endmodule

// ===== bench/timer16_interval_pwm_capture_tb.sv
// Purpose: Self-checking bench for the 16-bit timer
// Assumes: Register port with read data one cycle after the strobe
// Notes: PWM period check runs a full 65536-cycle wrap at sysclk/1
`timescale 1ns/1ns
module timer16_interval_pwm_capture_tb;
  import tmr16_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic ovf_ack_in = 1'b0;
  logic [7:0] rdata_out;
  logic ext_clk, cap_pin, pwm_pin, tog_pin, ovf_irq, mc_irq, irq_out;
  int bad_count = 0;
  int tests_run = 0;
  logic [7:0] rv;
  logic [7:0] rv2;
  int n;
  int m;
  always #2 clk_in = ~clk_in;
  tmr16_top u_tmr16_top (.clk_in(clk_in), .reset_in(reset_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .ovf_ack_in(ovf_ack_in),
    .external_count_clock_in(ext_clk), .capture_input_pin_in(cap_pin),
    .pulse_output_pin_out(pwm_pin), .toggle_output_pin_out(tog_pin),
    .overflow_irq_out(ovf_irq), .match_capture_irq_out(mc_irq),
    .irq_out(irq_out));
  tmr16_pin_model u_tmr16_pin_model (.clk_in(clk_in), .ext_clk_out(ext_clk),
    .cap_pin_out(cap_pin), .pulse_in(pwm_pin), .toggle_in(tog_pin));
  ////////////////////////////////////////////////////////////////////////
  // Bus cycles: strobes last exactly one cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chkreg(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, exp}, "register read");
  endtask
  // Cycles until a pin reaches a level, bounded
  task automatic wait_lvl(input logic lvl, input bit tog, output int c);
    c = 0;
    while (((tog ? tog_pin : pwm_pin) !== lvl) && c < 70000) begin
      @(posedge clk_in);
      #1;
      c++;
    end
  endtask
  task automatic give_verdict;
    $display("tests_run %0d bad_count %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the longest test, the PWM wrap
  initial begin
    #(4 * 90000);
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    chkreg(TMR16_ADDR_CTRL, 8'h00);
    chkreg(TMR16_ADDR_CNT_LO, 8'h00);
    chkreg(TMR16_ADDR_PCFG, 8'h00);
    $display("test reset done");
    // Dividers /1024 down to /8: clear, wait five timer periods, expect about five
    wr(TMR16_ADDR_REF_LO, 8'hFF);
    wr(TMR16_ADDR_REF_HI, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      wr(TMR16_ADDR_CTRL, {TMR16_SEL_D1024 + 3'(i), 5'h08});
      repeat ((1024 >> (2 * i + (i == 3))) * 5) @(posedge clk_in);
      rd(TMR16_ADDR_CNT_LO, rv);
      chk(16'(rv >= 8'h04 && rv <= 8'h06), 16'h0001, "divided count");
    end
    $display("test prescaler done");
    // Interval: match at 5 gives a period of six timer clocks
    wr(TMR16_ADDR_REF_LO, 8'h05);
    wr(TMR16_ADDR_REF_HI, 8'h00);
    wr(TMR16_ADDR_MASK, 8'h02);
    wr(TMR16_ADDR_CTRL, 8'h8A);
    wait_lvl(~tog_pin, 1'b1, n);
    wait_lvl(~tog_pin, 1'b1, n);
    chk(16'(n), 16'h0006, "toggle period");
    chk(16'(u_tmr16_pin_model.toggles >= 2), 16'h0001, "toggle load");
    for (int i = 0; i < 6; i++) begin
      rd(TMR16_ADDR_CNT_LO, rv);
      chk(16'(rv <= 8'h05), 16'h0001, "counter above reference");
    end
    chk({15'h0, mc_irq}, 16'h0001, "match irq");
    chk({15'h0, pwm_pin}, 16'h0000, "pulse outside pwm");
    chkreg(TMR16_ADDR_PEND, 8'h08);
    wr(TMR16_ADDR_CTRL, 8'hE2);
    rd(TMR16_ADDR_CNT_LO, rv);
    repeat (20) @(posedge clk_in);
    rd(TMR16_ADDR_CNT_LO, rv2);
    chk({8'h00, rv2}, {8'h00, rv}, "stopped counter");
    wr(TMR16_ADDR_CTRL, 8'hEA);
    chkreg(TMR16_ADDR_CNT_LO, 8'h00);
    wr(TMR16_ADDR_PEND, 8'h00);
    chkreg(TMR16_ADDR_PEND, 8'h00);
    chk({15'h0, irq_out}, 16'h0001, "masked-in status");
    chkreg(TMR16_ADDR_STAT, 8'h02);
    chkreg(TMR16_ADDR_STAT, 8'h00);
    chk({15'h0, irq_out}, 16'h0000, "status cleared");
    $display("test interval done");
    // Capture: external clock counts, pin edge loads the count
    wr(TMR16_ADDR_PCFG, 8'h04);
    wr(TMR16_ADDR_CTRL, 8'hAE);
    u_tmr16_pin_model.ext_pulses(7);
    u_tmr16_pin_model.cap_to(1'b1);
    chkreg(TMR16_ADDR_REF_LO, 8'h07);
    chkreg(TMR16_ADDR_REF_HI, 8'h00);
    chkreg(TMR16_ADDR_PEND, 8'h08);
    wr(TMR16_ADDR_PEND, 8'h00);
    u_tmr16_pin_model.cap_to(1'b0);
    chkreg(TMR16_ADDR_PEND, 8'h00);
    wr(TMR16_ADDR_CTRL, 8'hA2);
    u_tmr16_pin_model.ext_pulses(3);
    u_tmr16_pin_model.cap_to(1'b1);
    chkreg(TMR16_ADDR_PEND, 8'h00);
    u_tmr16_pin_model.cap_to(1'b0);
    chkreg(TMR16_ADDR_REF_LO, 8'h0A);
    chkreg(TMR16_ADDR_PEND, 8'h08);
    wr(TMR16_ADDR_CTRL, 8'hC2);
    u_tmr16_pin_model.ext_pulses(2);
    chkreg(TMR16_ADDR_CNT_LO, 8'h0C);
    $display("test capture done");
    // PWM: reference 16, low from 16 up to the wrap, high after it
    wr(TMR16_ADDR_PCFG, 8'h00);
    wr(TMR16_ADDR_REF_LO, 8'h10);
    wr(TMR16_ADDR_PEND, 8'h00);
    wr(TMR16_ADDR_CTRL, 8'h99);
    wait_lvl(1'b1, 1'b0, n);
    wait_lvl(1'b0, 1'b0, n);
    wait_lvl(1'b1, 1'b0, n);
    wait_lvl(1'b0, 1'b0, m);
    chk(16'(n + m), 16'h0000, "pwm period wraps");
    chk(16'(n + m - 65536), 16'h0000, "pwm period");
    chk(16'(m), 16'h0010, "pwm high span");
    chk(16'(u_tmr16_pin_model.pulse_rises >= 1), 16'h0001, "pulse load");
    chk({15'h0, ovf_irq}, 16'h0001, "overflow irq");
    chkreg(TMR16_ADDR_PEND, 8'h04);
    @(posedge clk_in);
    ovf_ack_in <= 1'b1;
    @(posedge clk_in);
    ovf_ack_in <= 1'b0;
    chkreg(TMR16_ADDR_PEND, 8'h00);
    chk({15'h0, ovf_irq}, 16'h0000, "overflow irq after ack");
    $display("test pwm done");
    give_verdict();
  end
endmodule
